// ===== core/mem_map_consts.svh
// Constants of the memory-organisation block: vectors, maps, bus offsets
// Assumes inclusion by bare name from the design module and the bench
`ifndef MEM_MAP_CONSTS_SVH
`define MEM_MAP_CONSTS_SVH

// ----------------------------------------------------------------
// Program memory and vectors
// ----------------------------------------------------------------
`define PM_DEPTH 8192
`define PC_W 13
`define VEC_RESET 13'h0000
`define VEC_EXT 13'h0004
`define VEC_TMR0 13'h0008
`define VEC_TMR1 13'h000C
`define VEC_PERIPH 13'h0010
`define VEC_RTC 13'h0014
`define VEC_MULTI 13'h0018
`define VEC_STEP 13'h0004
`define LAST_PAGE 5'h1F
`define INT_COUNT 6

// ----------------------------------------------------------------
// Data memory map
// ----------------------------------------------------------------
`define DM_DEPTH 2112
`define GP_BASE 8'h40
`define GP_PER_BANK 12'h0C0
`define BANK_COUNT 4'hB
`define BANK_RESET 4'h0
`define A_IND0 8'h00
`define A_MP0 8'h01
`define A_IND1 8'h02
`define A_MP1 8'h03
`define A_BANK 8'h04
`define A_TBLP 8'h07
`define A_TABLE_HIGH_BYTE 8'h08

// ----------------------------------------------------------------
// Bus offsets and fields
// ----------------------------------------------------------------
`define R_INT_EN 12'h000
`define R_INT_PEND 12'h004
`define R_PC 12'h008
`define R_PM_ADDR 12'h00C
`define R_PM_DATA 12'h010
`define R_TBL_CMD 12'h014
`define R_BIT_CMD 12'h018
`define DM_WIN_SEL 2'h1
`define TBL_LAST_BIT 8
`define BIT_SET_BIT 11

`endif

// ===== core/mem_map_pkg.sv
// Types of the memory-organisation block
// Assumes compilation before the design module
package mem_map_pkg;

    // ----------------------------------------------------------------
    // Table read sequencer
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        TS_IDLE = 3'b001,
        TS_FETCH = 3'b010,
        TS_STORE = 3'b100
    } tbl_state_t;

endpackage : mem_map_pkg

// ===== core/memory_map_core.sv
// Program store, vectors, table reads and banked data memory
// Assumes one 125 MHz clock, an Avalon-MM master and a CPU core beside it
//
// What this block does
// - Program store of 8K 16-bit words
// - Fetch restarts at 000H after reset
// - External low input vectors to 004H
// - Timer zero overflow vectors to 008H
// - Timer one overflow vectors to 00CH
// - Valid tone character vectors to 010H
// - Clock time-out vectors to 014H
// - Shared event sources vector to 018H
// - Table pointer gives low address byte
// - Upper table bits: current page or ones
// - Low byte to memory, high to register
// - Table read takes two cycles
// - Byte-wide data memory from 00H upward
// - Data memory has no power-on value
// - Eleven general banks chosen by selector
// - Single bit set and clear supported
// - Banks above zero only via pointer one
// - Unused special locations read 00H
// - Special registers ignore bank selection
// - Full stack holds request, no acknowledge
// - Reset clears bank except watchdog sleep
`timescale 1ns/10ps
`default_nettype none
`include "mem_map_consts.svh"

module memory_map_core (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic dev_reset,
    input wire logic wdt_pd_reset,
    input wire logic stack_full,
    input wire logic pc_advance,
    input wire logic ext_int_b,
    input wire logic tmr0_ovf,
    input wire logic tmr1_ovf,
    input wire logic dtmf_rx_en,
    input wire logic dtmf_valid,
    input wire logic rtc_en,
    input wire logic rtc_timeout,
    input wire logic port_c_bit_zero,
    input wire logic port_c_bit_five,
    input wire logic port_c_bit_seven,
    input wire logic serial_evt,
    input wire logic ext_periph_b,
    input wire logic tmr2_ovf,
    output logic [12:0] pc,
    output logic [15:0] instr_word,
    output logic vector_taken
);
    import mem_map_pkg::*;

    // ----------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------------------------------
    wire [4:0] pin_raw;
    logic [4:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_val_r, pin_prev_r;
    wire [4:0] pin_fall;
    wire [4:0] pin_rise;

    assign pin_raw = {ext_periph_b, port_c_bit_seven, port_c_bit_five, port_c_bit_zero, ext_int_b};

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_pin
            always_ff @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    pin_s1_r[gi] <= 1'b1;
                    pin_s2_r[gi] <= 1'b1;
                    pin_s3_r[gi] <= 1'b1;
                    pin_val_r[gi] <= 1'b1;
                    pin_prev_r[gi] <= 1'b1;
                end else begin
                    pin_s1_r[gi] <= pin_raw[gi];
                    pin_s2_r[gi] <= pin_s1_r[gi];
                    pin_s3_r[gi] <= pin_s2_r[gi];
                    if (pin_s2_r[gi] == pin_s3_r[gi]) begin
                        pin_val_r[gi] <= pin_s3_r[gi];
                    end
                    pin_prev_r[gi] <= pin_val_r[gi];
                end
            end
        end
    endgenerate

    assign pin_fall = pin_prev_r & ~pin_val_r;
    assign pin_rise = ~pin_prev_r & pin_val_r;

    // ----------------------------------------------------------------
    // Interrupt requests and vectoring
    // ----------------------------------------------------------------
    logic [5:0] int_en_r, int_pend_r, ack_mask;
    logic [12:0] pc_r, vec_addr;
    logic vector_taken_r;
    wire multi_evt;
    wire [5:0] int_evt;
    wire [5:0] int_ready;
    wire take;
    wire [5:0] pend_nxt;

    assign multi_evt = pin_fall[1] | pin_fall[2] | pin_rise[3] | serial_evt | pin_fall[4] | tmr2_ovf;
    assign int_evt = {multi_evt, rtc_timeout & rtc_en, dtmf_valid & dtmf_rx_en,
                      tmr1_ovf, tmr0_ovf, pin_fall[0]};
    assign int_ready = int_pend_r & int_en_r;
    assign take = (|int_ready) & ~stack_full & ~dev_reset;

    always_comb begin
        vec_addr = `VEC_RESET;
        ack_mask = 6'h00;
        for (int i = `INT_COUNT - 1; i >= 0; i--) begin
            if (int_ready[i]) begin
                vec_addr = 13'(`VEC_STEP * 13'(i + 1));
                ack_mask = 6'h00;
                ack_mask[i] = 1'b1;
            end
        end
    end

    assign pend_nxt = (int_pend_r & ~(take ? ack_mask : 6'h00)) | int_evt;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            int_pend_r <= 6'h00;
            vector_taken_r <= 1'b0;
        end else begin
            int_pend_r <= dev_reset ? 6'h00 : pend_nxt;
            vector_taken_r <= take;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pc_r <= `VEC_RESET;
        end else if (dev_reset) begin
            pc_r <= `VEC_RESET;
        end else if (take) begin
            pc_r <= vec_addr;
        end else if (pc_advance) begin
            pc_r <= pc_r + 13'h0001;
        end
    end

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    tbl_state_t state_r;
    logic rd_done_r;
    logic [31:0] readdata_r;
    wire sel_int_en, sel_pend, sel_pc, sel_pm_addr, sel_pm_data, sel_tbl, sel_bit, sel_dm;
    wire wr_go;
    wire [31:0] rd_mux;

    assign sel_int_en = avs_address == `R_INT_EN;
    assign sel_pend = avs_address == `R_INT_PEND;
    assign sel_pc = avs_address == `R_PC;
    assign sel_pm_addr = avs_address == `R_PM_ADDR;
    assign sel_pm_data = avs_address == `R_PM_DATA;
    assign sel_tbl = avs_address == `R_TBL_CMD;
    assign sel_bit = avs_address == `R_BIT_CMD;
    assign sel_dm = avs_address[11:10] == `DM_WIN_SEL;
    assign avs_waitrequest = (avs_read & ~rd_done_r) | (avs_write & sel_tbl & (state_r != TS_STORE));
    assign wr_go = avs_write & ~avs_waitrequest & avs_byteenable[0];
    assign avs_readdata = readdata_r;

    // ----------------------------------------------------------------
    // Program memory and table reads
    // ----------------------------------------------------------------
    logic [15:0] pmem [0:`PM_DEPTH-1];
    logic [12:0] pm_addr_r;
    logic [15:0] instr_r, tword_r;
    logic [7:0] tbl_dest_r, tblp_r, table_high_byte_r;
    logic tbl_last_r;
    wire [12:0] tbl_addr;

    assign tbl_addr = tbl_last_r ? {`LAST_PAGE, tblp_r} : {pc_r[12:8], tblp_r};

    always_ff @(posedge core_clk) begin
        if (wr_go && sel_pm_data) begin
            pmem[pm_addr_r] <= avs_writedata[15:0];
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pm_addr_r <= `VEC_RESET;
            instr_r <= 16'h0000;
            tword_r <= 16'h0000;
        end else begin
            instr_r <= pmem[pc_r];
            if (wr_go && sel_pm_addr) begin
                pm_addr_r <= avs_writedata[12:0];
            end else if (wr_go && sel_pm_data) begin
                pm_addr_r <= pm_addr_r + 13'h0001;
            end
            if (state_r == TS_FETCH) begin
                tword_r <= pmem[tbl_addr];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= TS_IDLE;
            tbl_dest_r <= 8'h00;
            tbl_last_r <= 1'b0;
        end else begin
            case (state_r)
                TS_IDLE: begin
                    if (avs_write && sel_tbl) begin
                        state_r <= TS_FETCH;
                        tbl_dest_r <= avs_writedata[7:0];
                        tbl_last_r <= avs_writedata[`TBL_LAST_BIT];
                    end
                end
                TS_FETCH: begin
                    state_r <= TS_STORE;
                end
                TS_STORE: begin
                    state_r <= TS_IDLE;
                end
                default: begin
                    state_r <= TS_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Data memory address resolution
    // ----------------------------------------------------------------
    logic [7:0] dmem [0:`DM_DEPTH-1];
    logic [7:0] mp0_r, mp1_r;
    logic [3:0] bank_r;
    wire [7:0] res_addr, eff, sfr_rd, dm_rd_data, bit_mask, bit_val, wr_val;
    wire ind0, ind1, null_tgt, is_gp, bank_ok, gp_valid, dm_we, sfr_we;
    wire [3:0] eff_bank;
    wire [11:0] gp_idx;

    assign res_addr = (state_r == TS_STORE) ? tbl_dest_r : (sel_bit ? avs_writedata[7:0] : avs_address[9:2]);
    assign ind0 = res_addr == `A_IND0;
    assign ind1 = res_addr == `A_IND1;
    assign eff = ind0 ? mp0_r : (ind1 ? mp1_r : res_addr);
    assign eff_bank = ind1 ? bank_r : `BANK_RESET;
    assign null_tgt = (ind0 | ind1) & ((eff == `A_IND0) | (eff == `A_IND1));
    assign is_gp = eff >= `GP_BASE;
    assign bank_ok = eff_bank < `BANK_COUNT;
    assign gp_idx = 12'({8'h00, eff_bank} * `GP_PER_BANK) + {4'h0, eff - `GP_BASE};
    assign gp_valid = ~null_tgt & is_gp & bank_ok;
    assign sfr_rd = (eff == `A_MP0) ? mp0_r :
                    (eff == `A_MP1) ? mp1_r :
                    (eff == `A_BANK) ? {4'h0, bank_r} :
                    (eff == `A_TBLP) ? tblp_r :
                    (eff == `A_TABLE_HIGH_BYTE) ? table_high_byte_r : 8'h00;
    assign dm_rd_data = null_tgt ? 8'h00 : (is_gp ? (bank_ok ? dmem[gp_idx] : 8'h00) : sfr_rd);
    assign bit_mask = 8'h01 << avs_writedata[10:8];
    assign bit_val = avs_writedata[`BIT_SET_BIT] ? (dm_rd_data | bit_mask) : (dm_rd_data & ~bit_mask);
    assign wr_val = (state_r == TS_STORE) ? tword_r[7:0] : (sel_bit ? bit_val : avs_writedata[7:0]);
    assign dm_we = (state_r == TS_STORE) | (wr_go & (sel_dm | sel_bit));
    assign sfr_we = dm_we & ~null_tgt & ~is_gp;

    always_ff @(posedge core_clk) begin
        if (dm_we && gp_valid) begin
            dmem[gp_idx] <= wr_val;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            mp0_r <= 8'h00;
            mp1_r <= 8'h00;
            tblp_r <= 8'h00;
            table_high_byte_r <= 8'h00;
        end else begin
            if (sfr_we && eff == `A_MP0) begin
                mp0_r <= wr_val;
            end
            if (sfr_we && eff == `A_MP1) begin
                mp1_r <= wr_val;
            end
            if (sfr_we && eff == `A_TBLP) begin
                tblp_r <= wr_val;
            end
            if (state_r == TS_STORE) begin
                table_high_byte_r <= tword_r[15:8];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            bank_r <= `BANK_RESET;
        end else if (dev_reset) begin
            if (!wdt_pd_reset) begin
                bank_r <= `BANK_RESET;
            end
        end else if (sfr_we && eff == `A_BANK) begin
            bank_r <= wr_val[3:0];
        end
    end

    // ----------------------------------------------------------------
    // Software registers and read path
    // ----------------------------------------------------------------
    assign rd_mux = sel_int_en ? {26'h0, int_en_r} :
                    sel_pend ? {26'h0, int_pend_r} :
                    sel_pc ? {19'h0, pc_r} :
                    sel_pm_addr ? {19'h0, pm_addr_r} :
                    sel_pm_data ? {16'h0, pmem[pm_addr_r]} :
                    sel_dm ? {24'h0, dm_rd_data} : 32'h0;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            int_en_r <= 6'h00;
            rd_done_r <= 1'b0;
            readdata_r <= 32'h0;
        end else begin
            if (wr_go && sel_int_en) begin
                int_en_r <= avs_writedata[5:0];
            end
            rd_done_r <= avs_read & ~rd_done_r;
            if (avs_read && !rd_done_r) begin
                readdata_r <= rd_mux;
            end
        end
    end

    assign pc = pc_r;
    assign instr_word = instr_r;
    assign vector_taken = vector_taken_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    property p_pc_reset;
        dev_reset |=> pc_r == `VEC_RESET;
    endproperty
    a_pc_reset: assert property (p_pc_reset) else $error("fetch did not restart at zero");

    property p_vec_ext;
        (take && int_ready[0]) |=> (pc_r == `VEC_EXT) && vector_taken_r;
    endproperty
    a_vec_ext: assert property (p_vec_ext) else $error("external vector wrong");

    property p_vec_tmr0;
        (take && int_ready[1:0] == 2'b10) |=> pc_r == `VEC_TMR0;
    endproperty
    a_vec_tmr0: assert property (p_vec_tmr0) else $error("timer zero vector wrong");

    property p_vec_multi;
        (take && int_ready == 6'h20) |=> pc_r == `VEC_MULTI && (!int_pend_r[5] || $past(int_evt[5]));
    endproperty
    a_vec_multi: assert property (p_vec_multi) else $error("shared vector wrong");

    property p_stack_hold;
        (stack_full && |int_ready && !dev_reset) |=>
            ((int_pend_r & $past(int_ready)) == $past(int_ready)) && !vector_taken_r;
    endproperty
    a_stack_hold: assert property (p_stack_hold) else $error("request lost on full stack");

    property p_tbl_two;
        (state_r == TS_IDLE && avs_write && sel_tbl) |=> state_r == TS_FETCH ##1 state_r == TS_STORE ##1 state_r == TS_IDLE;
    endproperty
    a_tbl_two: assert property (p_tbl_two) else $error("table read not two cycles");

    property p_tbl_last;
        (state_r == TS_FETCH && tbl_last_r) |=> tword_r == pmem[{`LAST_PAGE, $past(tblp_r)}];
    endproperty
    a_tbl_last: assert property (p_tbl_last) else $error("last page address wrong");

    property p_tbl_high;
        (state_r == TS_STORE) |=> table_high_byte_r == $past(tword_r[15:8]);
    endproperty
    a_tbl_high: assert property (p_tbl_high) else $error("high byte not loaded");

    property p_bank_reset;
        (dev_reset && !wdt_pd_reset) |=> bank_r == `BANK_RESET;
    endproperty
    a_bank_reset: assert property (p_bank_reset) else $error("bank not cleared");

    property p_bank_keep;
        (dev_reset && wdt_pd_reset) |=> $stable(bank_r);
    endproperty
    a_bank_keep: assert property (p_bank_keep) else $error("bank changed on sleep watchdog");

    property p_unused_zero;
        (avs_read && !avs_waitrequest && sel_dm && avs_address[9:2] > `A_BANK && avs_address[9:2] != `A_TBLP
            && avs_address[9:2] != `A_TABLE_HIGH_BYTE && avs_address[9:2] < `GP_BASE) |-> avs_readdata == 32'h0;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused location not zero");

    c_vector: cover property (vector_taken_r ##1 pc_r != `VEC_RESET);
    c_table: cover property (state_r == TS_FETCH ##1 state_r == TS_STORE);
    c_bank_hi: cover property (dm_we && gp_valid && eff_bank == 4'hA);
    c_stack_wait: cover property (stack_full && |int_ready ##1 !stack_full ##1 vector_taken_r);

endmodule : memory_map_core

`default_nettype wire

// ===== test/test_mcu_memory_map_vectors_tables.sv
// Self-checking bench for the memory-organisation block
// Assumes the design files and the constants header are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "mem_map_consts.svh"

module test_mcu_memory_map_vectors_tables;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [11:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic dev_reset = 1'b0, wdt_pd_reset = 1'b0, stack_full = 1'b0, pc_advance = 1'b0;
    logic ext_int_b = 1'b1, tmr0_ovf = 1'b0, tmr1_ovf = 1'b0, tmr2_ovf = 1'b0;
    logic dtmf_rx_en = 1'b1, dtmf_valid = 1'b0, rtc_en = 1'b1, rtc_timeout = 1'b0;
    logic port_c_bit_zero = 1'b1, port_c_bit_five = 1'b1, port_c_bit_seven = 1'b0;
    logic serial_evt = 1'b0, ext_periph_b = 1'b1;
    logic [12:0] pc;
    logic [15:0] instr_word;
    logic vector_taken;
    int n_mismatch = 0;
    int checks_done = 0;
    int waits;
    logic [31:0] rd;

    always #4 core_clk = ~core_clk;

    memory_map_core dut_u (.core_clk(core_clk), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .dev_reset(dev_reset), .wdt_pd_reset(wdt_pd_reset), .stack_full(stack_full),
        .pc_advance(pc_advance), .ext_int_b(ext_int_b), .tmr0_ovf(tmr0_ovf), .tmr1_ovf(tmr1_ovf),
        .dtmf_rx_en(dtmf_rx_en), .dtmf_valid(dtmf_valid), .rtc_en(rtc_en), .rtc_timeout(rtc_timeout),
        .port_c_bit_zero(port_c_bit_zero), .port_c_bit_five(port_c_bit_five),
        .port_c_bit_seven(port_c_bit_seven), .serial_evt(serial_evt), .ext_periph_b(ext_periph_b),
        .tmr2_ovf(tmr2_ovf), .pc(pc), .instr_word(instr_word), .vector_taken(vector_taken));

    // ----------------------------------------------------------------
    // Bus and check helpers
    // ----------------------------------------------------------------
    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        waits = 0;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0) begin
            waits++;
            @(posedge core_clk);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus

    function automatic logic [11:0] dm(input logic [7:0] a);
        return {2'h1, a, 2'h0};
    endfunction : dm

    task drive_src(input int s, input logic on);
        case (s)
            0: ext_int_b <= !on;
            1: tmr0_ovf <= on;
            2: tmr1_ovf <= on;
            3: dtmf_valid <= on;
            4: rtc_timeout <= on;
            5: serial_evt <= on;
            6: port_c_bit_seven <= on;
            7: tmr2_ovf <= on;
            8: port_c_bit_zero <= !on;
            9: port_c_bit_five <= !on;
            default: ext_periph_b <= !on;
        endcase
    endtask : drive_src

    // Drives source s, releases it hold+1 edges later, records vectors seen
    task watch(input int s, input int hold, output int hits, output logic [12:0] v0, output logic [12:0] v1);
        int k;
        hits = 0;
        v0 = '0;
        v1 = '0;
        if (s >= 0) begin
            @(posedge core_clk);
            drive_src(s, 1'b1);
        end
        for (k = 0; k < 30; k++) begin
            @(posedge core_clk);
            if (s >= 0 && k == hold) begin
                drive_src(s, 1'b0);
            end
            if (vector_taken === 1'b1) begin
                if (hits == 0) v0 = pc;
                if (hits == 1) v1 = pc;
                hits++;
            end
        end
    endtask : watch

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_reset;
        bus(1'b0, `R_PC, 0);
        chk("pc after reset", 32'h0, rd);
        @(posedge core_clk);
        pc_advance <= 1'b1;
        @(posedge core_clk);
        pc_advance <= 1'b0;
        bus(1'b0, `R_PC, 0);
        chk("pc advanced", 32'h1, rd);
        @(posedge core_clk);
        dev_reset <= 1'b1;
        @(posedge core_clk);
        dev_reset <= 1'b0;
        bus(1'b0, `R_PC, 0);
        chk("pc after device reset", 32'h0, rd);
    endtask : t_reset

    task t_table;
        bus(1'b1, `R_PM_ADDR, 32'h0);
        bus(1'b1, `R_PM_DATA, 32'h5A3C);
        repeat (2) @(posedge core_clk);
        chk("fetched word", 32'h5A3C, {16'h0, instr_word});
        bus(1'b1, `R_PM_ADDR, 32'h6);
        bus(1'b1, `R_PM_DATA, 32'h1234);
        bus(1'b1, `R_PM_ADDR, 32'h1F06);
        bus(1'b1, `R_PM_DATA, 32'h0F1A);
        bus(1'b1, `R_PM_ADDR, 32'h1F06);
        bus(1'b0, `R_PM_DATA, 0);
        chk("program word", 32'h0F1A, rd);
        bus(1'b1, dm(8'h07), 32'h06);
        bus(1'b1, `R_TBL_CMD, 32'h041);
        chk("table wait cycles", 32'h2, 32'(waits));
        bus(1'b0, dm(8'h41), 0);
        chk("table low current page", 32'h34, rd);
        bus(1'b0, dm(8'h08), 0);
        chk("table high current page", 32'h12, rd);
        bus(1'b1, `R_TBL_CMD, 32'h140);
        bus(1'b0, dm(8'h40), 0);
        chk("table low last page", 32'h1A, rd);
        bus(1'b0, dm(8'h08), 0);
        chk("table high last page", 32'h0F, rd);
    endtask : t_table

    task t_banks;
        bus(1'b1, dm(8'h05), 32'h77);
        bus(1'b0, dm(8'h05), 0);
        chk("unused location", 32'h0, rd);
        bus(1'b1, dm(8'h04), 32'h3);
        bus(1'b1, dm(8'h03), 32'h50);
        bus(1'b1, dm(8'h02), 32'hA5);
        bus(1'b1, dm(8'h50), 32'h11);
        bus(1'b1, dm(8'h01), 32'h50);
        bus(1'b0, dm(8'h02), 0);
        chk("bank 3 via window one", 32'hA5, rd);
        bus(1'b0, dm(8'h00), 0);
        chk("bank 0 via window zero", 32'h11, rd);
        bus(1'b0, dm(8'h07), 0);
        chk("special reg in bank 3", 32'h06, rd);
        bus(1'b1, `R_BIT_CMD, 32'hF50);
        bus(1'b0, dm(8'h50), 0);
        chk("bit set", 32'h91, rd);
        bus(1'b1, `R_BIT_CMD, 32'h050);
        bus(1'b1, `R_BIT_CMD, 32'h902);
        bus(1'b0, dm(8'h50), 0);
        chk("bit clear", 32'h90, rd);
        bus(1'b0, dm(8'h02), 0);
        chk("bit set banked", 32'hA7, rd);
        @(posedge core_clk);
        dev_reset <= 1'b1;
        wdt_pd_reset <= 1'b1;
        @(posedge core_clk);
        dev_reset <= 1'b0;
        wdt_pd_reset <= 1'b0;
        bus(1'b0, dm(8'h04), 0);
        chk("bank kept", 32'h3, rd);
        @(posedge core_clk);
        dev_reset <= 1'b1;
        @(posedge core_clk);
        dev_reset <= 1'b0;
        bus(1'b0, dm(8'h04), 0);
        chk("bank cleared", 32'h0, rd);
    endtask : t_banks

    task t_vectors;
        int s, idx, hits;
        logic [12:0] v0, v1;
        for (s = 0; s <= 10; s++) begin
            idx = (s > 5) ? 5 : s;
            bus(1'b1, `R_INT_EN, 32'h1 << idx);
            watch(s, (s == 0 || s == 6 || s >= 8) ? 4 : 0, hits, v0, v1);
            chk("vector address", 32'h4 * (idx + 1), {19'h0, v0});
            chk("vector count", 32'h1, 32'(hits));
            bus(1'b1, `R_INT_EN, 32'h0);
        end
    endtask : t_vectors

    task t_gate;
        int hits;
        logic [12:0] v0, v1;
        watch(2, 0, hits, v0, v1);
        chk("disabled vector count", 32'h0, 32'(hits));
        @(posedge core_clk);
        stack_full <= 1'b1;
        bus(1'b1, `R_INT_EN, 32'h6);
        watch(1, 0, hits, v0, v1);
        chk("stack full vector count", 32'h0, 32'(hits));
        bus(1'b0, `R_INT_PEND, 0);
        chk("pending held", 32'h6, rd);
        @(posedge core_clk);
        stack_full <= 1'b0;
        watch(-1, 0, hits, v0, v1);
        chk("first served", 32'h8, {19'h0, v0});
        chk("second served", 32'hC, {19'h0, v1});
        bus(1'b0, `R_INT_PEND, 0);
        chk("pending cleared", 32'h0, rd);
    endtask : t_gate

    // ----------------------------------------------------------------
    // Run control
    // ----------------------------------------------------------------
    task close_out;
        $display("Mismatches %0d of %0d checks", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out

    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        close_out();
    end

    initial begin
        repeat (4) @(posedge core_clk);
        rst_b <= 1'b1;
        t_reset();
        t_table();
        t_banks();
        t_vectors();
        t_gate();
        close_out();
    end
endmodule : test_mcu_memory_map_vectors_tables

`default_nettype wire
